// ==== rtl/dpb_burst_sram.sv ====
// Four-word burst static memory with split read and write ports
// Operation
// - Read and write addresses share one bus on alternate primary clock edges.
// - Each address holds four words moved in sequence as one burst.
// - Words move on every rising edge of either input clock.
// - Only rising edges of the two input clocks time transfers.
// - Latency pin high: read data starts 2.5 cycles after address capture.
// - Latency pin low: read data starts one cycle after address capture.
// - A valid flag marks each cycle carrying a read burst word.
// - Echo clocks run beside the read data for capture.
// - Reads and writes proceed independently and may overlap.
// - Each port has its own select; unselected requests are ignored.
// - Address, selects, write data and lane selects are registered first.
// - Read data leaves through output registers on the input clocks.
// - Internal self-timed logic writes the array once a burst is captured.
// - Reads return the newest value, including a write still in flight.
module dpb_burst_sram #(
   parameter int DATA_W = dpb_pkg::DEF_DATA_W,
   parameter int ADDR_W = dpb_pkg::DEF_ADDR_W
) (
   input  wire logic                                   i_mclk,
   input  wire logic                                   i_arst_n,
   input  wire logic                                   i_kclk,
   input  wire logic                                   i_kclk_n,
   input  wire logic                                   i_latency_select_pin,
   input  wire logic [ADDR_W-1:0]                      i_addr,
   input  wire logic                                   i_rd_port_sel_n,
   input  wire logic                                   i_wr_port_sel_n,
   input  wire logic [DATA_W-1:0]                      i_wr_data,
   input  wire logic [DATA_W/dpb_pkg::LANE_W-1:0]      i_byte_write_select_n,
   output logic      [DATA_W-1:0]                      o_rd_data_k,
   output logic      [DATA_W-1:0]                      o_rd_data_kn,
   output logic                                        o_read_data_valid_flag_k,
   output logic                                        o_read_data_valid_flag_kn,
   output logic                                        o_read_echo_clock,
   output logic                                        o_read_echo_clock_n
);
   import dpb_pkg::*;

   localparam int BW      = DATA_W / LANE_W;
   localparam int BURST_W = BURST_LEN * DATA_W;
   localparam int MASK_W  = BURST_LEN * BW;

   // ***********************************************
   // Declarations
   // ***********************************************
   logic [2:0]              lat_pin_ff;
   logic                    lat_mode_ff;
   logic                    nxt_lat_mode;
   logic                    lat_long;
   dpb_slot_t               phase_ff;
   dpb_slot_t               in_slot_ff;
   logic [ADDR_W-1:0]       in_addr_ff;
   logic                    in_rsel_n_ff;
   logic                    in_wsel_n_ff;
   logic [DATA_W-1:0]       in_dk_ff;
   logic [BW-1:0]           in_bk_n_ff;
   logic [DATA_W-1:0]       in_dkn_ff;
   logic [BW-1:0]           in_bkn_n_ff;
   logic                    rd_acc;
   logic                    wr_acc;
   logic [ADDR_W-1:0]       wst_addr_ff;
   logic [HALF_LEN*DATA_W-1:0] wst_data_ff;
   logic [HALF_LEN*BW-1:0]  wst_mask_n_ff;
   logic                    wpend_ff;
   logic [BURST_W-1:0]      commit_data;
   logic [MASK_W-1:0]       commit_mask_n;
   logic [BURST_W-1:0]      arr_rdata;
   logic [BURST_W-1:0]      rd_words;
   logic                    byp_hit;
   logic [BURST_W-1:0]      rd_buf1_ff;
   logic [BURST_W-1:0]      rd_buf2_ff;
   logic [TOK_DEPTH-1:0]    rd_tok_ff;
   logic                    k_launch;
   logic [DATA_W-1:0]       k_word;
   logic                    kn_launch;
   logic [DATA_W-1:0]       kn_word;
   logic [DATA_W-1:0]       rw_w0;
   logic [DATA_W-1:0]       b1_w1;
   logic [DATA_W-1:0]       b1_w2;
   logic [DATA_W-1:0]       b1_w3;
   logic [DATA_W-1:0]       b2_w0;
   logic [DATA_W-1:0]       b2_w1;
   logic [DATA_W-1:0]       b2_w2;
   logic [DATA_W-1:0]       b2_w3;

   // ***********************************************
   // Latency pin, system clock side
   // ***********************************************

   // Three-stage pin capture, change taken once stages two and three agree
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lat_pin_ff  <= {3{RST_LAT_MODE}};
         lat_mode_ff <= RST_LAT_MODE;
      end else begin
         lat_pin_ff  <= {lat_pin_ff[1:0], i_latency_select_pin};
         lat_mode_ff <= nxt_lat_mode;
      end
   end

   assign nxt_lat_mode = (lat_pin_ff[1] == lat_pin_ff[2]) ? lat_pin_ff[2] : lat_mode_ff;

   // Filtered mode level crosses into the link domain
   dpb_sync2 u_lat_sync (
      .i_clk    (i_kclk),
      .i_arst_n (i_arst_n),
      .i_level  (lat_mode_ff),
      .o_level  (lat_long)
   );

   // ***********************************************
   // Input registers on both input clocks
   // ***********************************************

   // Address, selects and even words on the primary clock
   always_ff @(posedge i_kclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase_ff     <= SLOT_READ;
         in_slot_ff   <= SLOT_READ;
         in_addr_ff   <= '0;
         in_rsel_n_ff <= RST_SEL_N;
         in_wsel_n_ff <= RST_SEL_N;
         in_dk_ff     <= '0;
         in_bk_n_ff   <= '1;
      end else begin
         phase_ff     <= (phase_ff == SLOT_READ) ? SLOT_WRITE : SLOT_READ;
         in_slot_ff   <= phase_ff;
         in_addr_ff   <= i_addr;
         in_rsel_n_ff <= i_rd_port_sel_n;
         in_wsel_n_ff <= i_wr_port_sel_n;
         in_dk_ff     <= i_wr_data;
         in_bk_n_ff   <= i_byte_write_select_n;
      end
   end

   // Odd words on the complementary clock
   always_ff @(posedge i_kclk_n or negedge i_arst_n) begin
      if (!i_arst_n) begin
         in_dkn_ff   <= '0;
         in_bkn_n_ff <= '1;
      end else begin
         in_dkn_ff   <= i_wr_data;
         in_bkn_n_ff <= i_byte_write_select_n;
      end
   end

   // Slot decode gated by each port's own select
   always_comb begin
      rd_acc = 1'h0;
      wr_acc = 1'h0;
      case (in_slot_ff)
         SLOT_READ: begin
            rd_acc = !in_rsel_n_ff;
         end
         SLOT_WRITE: begin
            wr_acc = !in_wsel_n_ff;
         end
         default: begin
            rd_acc = 1'h0;
            wr_acc = 1'h0;
         end
      endcase
   end

   // ***********************************************
   // Write path
   // ***********************************************

   // First two words held until the second half arrives
   always_ff @(posedge i_kclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wst_addr_ff   <= '0;
         wst_data_ff   <= '0;
         wst_mask_n_ff <= '1;
         wpend_ff      <= RST_PEND;
      end else begin
         wpend_ff <= wr_acc;
         if (wr_acc) begin
            wst_addr_ff   <= in_addr_ff;
            wst_data_ff   <= {in_dkn_ff, in_dk_ff};
            wst_mask_n_ff <= {in_bkn_n_ff, in_bk_n_ff};
         end
      end
   end

   // Whole burst, word zero in the low bits
   assign commit_data   = {in_dkn_ff, in_dk_ff, wst_data_ff};
   assign commit_mask_n = {in_bkn_n_ff, in_bk_n_ff, wst_mask_n_ff};

   // Array written by the internal commit, reads on the same edge
   dpb_burst_array #(
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W)
   ) u_array (
      .i_clk     (i_kclk),
      .i_we      (wpend_ff),
      .i_waddr   (wst_addr_ff),
      .i_wdata   (commit_data),
      .i_wmask_n (commit_mask_n),
      .i_raddr   (in_addr_ff),
      .o_rdata   (arr_rdata)
   );

   // ***********************************************
   // Read path
   // ***********************************************

   // Forward lanes of a commit landing on the same edge
   assign byp_hit = wpend_ff && (wst_addr_ff == in_addr_ff);

   for (genvar g = 0; g < MASK_W; g++) begin : g_byp
      assign rd_words[g*LANE_W +: LANE_W] = (byp_hit && !commit_mask_n[g]) ?
                                            commit_data[g*LANE_W +: LANE_W] :
                                            arr_rdata[g*LANE_W +: LANE_W];
   end

   // Two burst buffers cover overlap of back-to-back reads
   always_ff @(posedge i_kclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rd_buf1_ff <= '0;
         rd_buf2_ff <= '0;
         rd_tok_ff  <= '0;
      end else begin
         rd_buf1_ff <= rd_acc ? rd_words : rd_buf1_ff;
         rd_buf2_ff <= rd_buf1_ff;
         rd_tok_ff  <= {rd_tok_ff[TOK_DEPTH-2:0], rd_acc};
      end
   end

   // Word picks from lookup and buffers
   assign rw_w0 = rd_words[0 +: DATA_W];
   assign b1_w1 = rd_buf1_ff[1*DATA_W +: DATA_W];
   assign b1_w2 = rd_buf1_ff[2*DATA_W +: DATA_W];
   assign b1_w3 = rd_buf1_ff[3*DATA_W +: DATA_W];
   assign b2_w0 = rd_buf2_ff[0 +: DATA_W];
   assign b2_w1 = rd_buf2_ff[1*DATA_W +: DATA_W];
   assign b2_w2 = rd_buf2_ff[2*DATA_W +: DATA_W];
   assign b2_w3 = rd_buf2_ff[3*DATA_W +: DATA_W];

   // Primary clock launches
   assign k_launch = lat_long ? (rd_tok_ff[TOK_LAT25_W1] | rd_tok_ff[TOK_LAT25_W3]) :
                                (rd_acc | rd_tok_ff[TOK_LAT1_W2]);
   assign k_word   = lat_long ? (rd_tok_ff[TOK_LAT25_W1] ? b2_w1 : b2_w3) :
                                (rd_acc ? rw_w0 : b1_w2);

   // Complementary clock launches
   assign kn_launch = lat_long ? (rd_tok_ff[TOK_LAT25_W1] | rd_tok_ff[TOK_LAT25_W3]) :
                                 (rd_tok_ff[0] | rd_tok_ff[1]);
   assign kn_word   = lat_long ? (rd_tok_ff[TOK_LAT25_W1] ? b2_w0 : b2_w2) :
                                 (rd_tok_ff[0] ? b1_w1 : b1_w3);

   // Output registers and echo on the primary clock
   always_ff @(posedge i_kclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rd_data_k              <= '0;
         o_read_data_valid_flag_k <= RST_FLAG;
         o_read_echo_clock        <= RST_FLAG;
      end else begin
         o_rd_data_k              <= k_launch ? k_word : o_rd_data_k;
         o_read_data_valid_flag_k <= k_launch;
         o_read_echo_clock        <= ~o_read_echo_clock;
      end
   end

   // Output registers and echo on the complementary clock
   always_ff @(posedge i_kclk_n or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rd_data_kn              <= '0;
         o_read_data_valid_flag_kn <= RST_FLAG;
         o_read_echo_clock_n       <= RST_FLAG;
      end else begin
         o_rd_data_kn              <= kn_launch ? kn_word : o_rd_data_kn;
         o_read_data_valid_flag_kn <= kn_launch;
         o_read_echo_clock_n       <= ~o_read_echo_clock_n;
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************

   // Address slot flips every primary edge
   a_slot_alternate: assert property (@(posedge i_kclk) disable iff (!i_arst_n)
      $past(i_arst_n) |-> phase_ff != $past(phase_ff))
      else $error("address slot did not alternate");

   // Read taken only in its slot with its select
   a_rd_select: assert property (@(posedge i_kclk) disable iff (!i_arst_n)
      rd_acc |-> (in_slot_ff == SLOT_READ) && !in_rsel_n_ff && !wr_acc)
      else $error("read taken outside its slot or select");

   // Captured write commits on the next edge
   a_wr_commit: assert property (@(posedge i_kclk) disable iff (!i_arst_n)
      wr_acc |=> wpend_ff && (wst_addr_ff == $past(in_addr_ff)))
      else $error("write burst not committed");

   // Short latency: valid on both lanes for two cycles
   a_lat_short: assert property (@(posedge i_kclk) disable iff (!i_arst_n)
      rd_acc && !lat_long |-> ##1 (o_read_data_valid_flag_k && o_read_data_valid_flag_kn)
      ##1 (o_read_data_valid_flag_k && o_read_data_valid_flag_kn))
      else $error("short latency burst misplaced");

   // Long latency: complementary (even word) lane first, then both lanes, then the primary (odd word) lane last
   a_lat_long: assert property (@(posedge i_kclk) disable iff (!i_arst_n)
      rd_acc && lat_long |-> ##2 o_read_data_valid_flag_kn
      ##1 (o_read_data_valid_flag_k && o_read_data_valid_flag_kn) ##1 o_read_data_valid_flag_k)
      else $error("long latency burst misplaced");

   // First word of a short latency read
   a_first_word: assert property (@(posedge i_kclk) disable iff (!i_arst_n)
      rd_acc && !lat_long |=> o_rd_data_k == $past(rw_w0))
      else $error("first read word wrong");

   // Data holds while the flag is low
   a_valid_hold: assert property (@(posedge i_kclk) disable iff (!i_arst_n)
      !o_read_data_valid_flag_k |-> $stable(o_rd_data_k))
      else $error("read data moved without valid");

   // Echo clock runs every primary edge
   a_echo_runs: assert property (@(posedge i_kclk) disable iff (!i_arst_n)
      $past(i_arst_n) |-> o_read_echo_clock != $past(o_read_echo_clock))
      else $error("echo clock stalled");

   // Full-lane write in flight is forwarded to a same-address read
   a_bypass_data: assert property (@(posedge i_kclk) disable iff (!i_arst_n)
      rd_acc && byp_hit && !(|commit_mask_n) |=> rd_buf1_ff == $past(commit_data))
      else $error("in-flight write not forwarded");

   c_rd_short: cover property (@(posedge i_kclk) disable iff (!i_arst_n)
      rd_acc && !lat_long);
   c_rd_long: cover property (@(posedge i_kclk) disable iff (!i_arst_n)
      rd_acc && lat_long);
   c_overlap: cover property (@(posedge i_kclk) disable iff (!i_arst_n)
      rd_acc && wpend_ff);
   c_bypass: cover property (@(posedge i_kclk) disable iff (!i_arst_n)
      rd_acc && byp_hit);

endmodule

// ==== rtl/dpb_pkg.sv ====
// Shared constants and types for the burst static memory model
package dpb_pkg;

   // ***********************************************
   // Geometry
   // ***********************************************
   localparam int DEF_DATA_W = 18;      // Word width, 18 or 36
   localparam int DEF_ADDR_W = 19;      // Burst address width
   localparam int BURST_LEN  = 4;       // Words per address
   localparam int LANE_W     = 9;       // Bits per byte-write lane
   localparam int HALF_LEN   = 2;       // Words captured before commit

   // ***********************************************
   // Read launch tokens
   // ***********************************************
   localparam int TOK_DEPTH    = 3;     // Read token shift depth
   localparam int TOK_LAT1_W2  = 0;     // Short latency, third word
   localparam int TOK_LAT25_W1 = 1;     // Long latency, second word
   localparam int TOK_LAT25_W3 = 2;     // Long latency, fourth word

   // ***********************************************
   // Reset values
   // ***********************************************
   localparam logic RST_SEL_N    = 1'h1;  // Port selects idle deselected
   localparam logic RST_LAT_MODE = 1'h1;  // Long latency until pin seen
   localparam logic RST_FLAG     = 1'h0;  // Valid flags and echo clocks
   localparam logic RST_PEND     = 1'h0;  // No write in flight

   // Address bus slot, alternates on every primary clock edge
   typedef enum logic {
      SLOT_READ  = 1'h0,
      SLOT_WRITE = 1'h1
   } dpb_slot_t;

endpackage

// ==== rtl/dpb_sync2.sv ====
// Two-stage level synchroniser into the link clock domain
module dpb_sync2 (
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   input  wire logic i_level,
   output logic      o_level
);
   import dpb_pkg::*;

   logic meta_ff;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_ff <= RST_LAT_MODE;
         o_level <= RST_LAT_MODE;
      end else begin
         meta_ff <= i_level;
         o_level <= meta_ff;
      end
   end

endmodule

// ==== rtl/dpb_burst_array.sv ====
// Burst-wide storage array with per-lane write masks
module dpb_burst_array #(
   parameter int ADDR_W = dpb_pkg::DEF_ADDR_W,
   parameter int DATA_W = dpb_pkg::DEF_DATA_W
) (
   input  wire logic                                                  i_clk,
   input  wire logic                                                  i_we,
   input  wire logic [ADDR_W-1:0]                                     i_waddr,
   input  wire logic [dpb_pkg::BURST_LEN*DATA_W-1:0]                  i_wdata,
   input  wire logic [dpb_pkg::BURST_LEN*DATA_W/dpb_pkg::LANE_W-1:0]  i_wmask_n,
   input  wire logic [ADDR_W-1:0]                                     i_raddr,
   output logic      [dpb_pkg::BURST_LEN*DATA_W-1:0]                  o_rdata
);
   import dpb_pkg::*;

   localparam int BURST_W = BURST_LEN * DATA_W;
   localparam int LANES   = BURST_W / LANE_W;

   logic [BURST_W-1:0] mem [2**ADDR_W];

   // Self-timed burst write, masked lanes keep old contents
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         for (int l = 0; l < LANES; l++) begin
            if (!i_wmask_n[l]) begin
               mem[i_waddr][l*LANE_W +: LANE_W] <= i_wdata[l*LANE_W +: LANE_W];
            end
         end
      end
   end

   // Flow-through lookup, registered by the caller
   assign o_rdata = mem[i_raddr];

endmodule

// ==== bench/dpb_ctrl_model.sv ====
// Memory controller model driving the link clocks, address bus and write port
module dpb_ctrl_model #(
   parameter int DATA_W = 18,
   parameter int ADDR_W = 6,
   parameter int MW     = DATA_W / dpb_pkg::LANE_W
) (
   input  wire logic              i_arst_n,
   output logic                   o_kclk,
   output logic                   o_kclk_n,
   output logic [ADDR_W-1:0]      o_addr,
   output logic                   o_rd_sel_n,
   output logic                   o_wr_sel_n,
   output logic [DATA_W-1:0]      o_wr_data,
   output logic [MW-1:0]          o_byte_sel_n
);
   timeunit 1ns;
   timeprecision 100ps;
   import dpb_pkg::*;

   int                  kcnt = 0;    // Primary clock edges since release
   int                  h    = 0;    // Rising edges of either clock
   int                  rd_h = 0;    // Half-edge index of last read capture
   logic                pv   = 1'h0; // Words of a write still to be sent
   logic [3*DATA_W-1:0] pd;
   logic [3*MW-1:0]     pm;

   // ***********************************************
   // Complementary clock pair, free running
   // ***********************************************
   initial begin
      o_kclk = 1'h0;
      o_kclk_n = 1'h1;
      o_addr = '0;
      o_rd_sel_n = 1'h1;
      o_wr_sel_n = 1'h1;
      o_wr_data = '0;
      o_byte_sel_n = '1;
      #2.5;
      forever begin
         #6;
         o_kclk = ~o_kclk;
         o_kclk_n = ~o_kclk_n;
      end
   end

   // Edge counters that track the address bus slot
   always @(posedge o_kclk or negedge i_arst_n) kcnt <= i_arst_n ? kcnt + 1 : 0;
   always @(posedge o_kclk or posedge o_kclk_n or negedge i_arst_n) h <= i_arst_n ? h + 1 : 0;
   always @(negedge i_arst_n) pv = 1'h0;

   // Drive a word, or the inverse of the last one when the lines are free
   task automatic put(input logic v, input logic [DATA_W-1:0] d, input logic [MW-1:0] m);
      if (v) begin
         o_wr_data = d;
         o_byte_sel_n = m;
      end else begin
         o_wr_data = ~o_wr_data;
         o_byte_sel_n = ~o_byte_sel_n;
      end
   endtask

   // ***********************************************
   // One read slot then one write slot
   // ***********************************************
   task automatic pair(input logic rs_n, input logic [ADDR_W-1:0] ra, input logic ws_n,
                       input logic [ADDR_W-1:0] wa, input logic [4*DATA_W-1:0] wd,
                       input logic [4*MW-1:0] wm);
      do begin
         @(posedge o_kclk);
         #1;
      end while (kcnt % 2 != 0);
      o_addr = ra;
      o_rd_sel_n = rs_n;
      o_wr_sel_n = 1'h1;
      put(pv, pd[0 +: DATA_W], pm[0 +: MW]);
      @(posedge o_kclk_n);
      #1;
      put(pv, pd[DATA_W +: DATA_W], pm[MW +: MW]);
      @(posedge o_kclk);
      #1;
      if (!rs_n) rd_h = h;
      o_addr = wa;
      o_rd_sel_n = 1'h1;
      o_wr_sel_n = ws_n;
      put(pv, pd[2*DATA_W +: DATA_W], pm[2*MW +: MW]);
      @(posedge o_kclk_n);
      #1;
      put(!ws_n, wd[0 +: DATA_W], wm[0 +: MW]);
      pv = !ws_n;
      pd = wd[4*DATA_W-1:DATA_W];
      pm = wm[4*MW-1:MW];
   endtask
endmodule

// ==== bench/dpb_burst_sram_test.sv ====
// Self-checking bench for the burst static memory in both latency modes
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module dpb_burst_sram_test;
   timeunit 1ns;
   timeprecision 100ps;
   import dpb_pkg::*;

   localparam int DW = 18;
   localparam int AW = 6;
   localparam int MW = DW / LANE_W;
   localparam int BW = BURST_LEN * DW;
   localparam logic [BW-1:0] W1 = 72'h123456789ABCDEF012;
   localparam logic [BW-1:0] W2 = 72'h0F0F0F0F0F0F0F0F0F;
   localparam logic [BW-1:0] W3 = 72'hFEDCBA987654321001;
   localparam logic [7:0]    MK = 8'hA6;

   logic           mclk = 1'h0;
   logic           arst_n = 1'h0;
   logic           lat_pin = 1'h0;
   logic           kclk, kclk_n, rsel_n, wsel_n;
   logic [AW-1:0]  addr;
   logic [DW-1:0]  wdata, rd_k, rd_kn;
   logic [MW-1:0]  byte_sel_n;
   logic           vld_k, vld_kn, echo, echo_n;
   int             error_cnt = 0;
   int             n_compared = 0;
   int             cyc = 0;
   logic [DW-1:0]  rq[$];
   int             rh[$];
   int             hq[$];

   // ***********************************************
   // Clock, device and controller
   // ***********************************************
   initial forever #2 mclk = ~mclk;

   dpb_ctrl_model #(.DATA_W(DW), .ADDR_W(AW)) ctl (
      .i_arst_n(arst_n), .o_kclk(kclk), .o_kclk_n(kclk_n), .o_addr(addr),
      .o_rd_sel_n(rsel_n), .o_wr_sel_n(wsel_n), .o_wr_data(wdata), .o_byte_sel_n(byte_sel_n));

   dpb_burst_sram #(.DATA_W(DW), .ADDR_W(AW)) dut (
      .i_mclk(mclk), .i_arst_n(arst_n), .i_kclk(kclk), .i_kclk_n(kclk_n),
      .i_latency_select_pin(lat_pin), .i_addr(addr), .i_rd_port_sel_n(rsel_n),
      .i_wr_port_sel_n(wsel_n), .i_wr_data(wdata), .i_byte_write_select_n(byte_sel_n),
      .o_rd_data_k(rd_k), .o_rd_data_kn(rd_kn), .o_read_data_valid_flag_k(vld_k),
      .o_read_data_valid_flag_kn(vld_kn), .o_read_echo_clock(echo),
      .o_read_echo_clock_n(echo_n));

   // Collect valid read words in time order with their half-edge index
   always @(posedge kclk) begin
      #1;
      if (vld_k === 1'h1) begin
         rq.push_back(rd_k);
         rh.push_back(ctl.h);
      end
   end
   always @(posedge kclk_n) begin
      #1;
      if (vld_kn === 1'h1) begin
         rq.push_back(rd_kn);
         rh.push_back(ctl.h);
      end
   end

   // Hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         print_verdict();
      end
   end

   // ***********************************************
   // Shared helpers
   // ***********************************************
   function automatic logic [BW-1:0] merge(input logic [BW-1:0] o, input logic [BW-1:0] n,
                                           input logic [BURST_LEN*MW-1:0] m);
      logic [BW-1:0] r;
      r = o;
      for (int i = 0; i < BURST_LEN*MW; i++) if (!m[i]) r[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
      return r;
   endfunction

   task automatic op(input logic rs, input logic [AW-1:0] ra, input logic ws,
                     input logic [AW-1:0] wa, input logic [BW-1:0] d, input logic [7:0] m);
      ctl.pair(rs, ra, ws, wa, d, m);
      if (!rs) hq.push_back(ctl.rd_h);
   endtask

   task automatic clr();
      rq.delete();
      rh.delete();
      hq.delete();
   endtask

   // Flush the write lines, let bursts drain, count the words seen
   task automatic done(input int n);
      op(1'h1, 6'h00, 1'h1, 6'h00, '0, 8'hFF);
      repeat (6) @(posedge kclk);
      `CHK(rq.size(), 4*n);
   endtask

   // Burst k: words in order, first word 1 or 2.5 cycles after capture
   task automatic chk_burst(input int k, input logic [BW-1:0] exp);
      int lat;
      lat = lat_pin ? 5 : 2;
      for (int i = 0; i < BURST_LEN; i++) begin
         `CHK(rq[4*k+i], exp[i*DW +: DW]);
         `CHK(rh[4*k+i] - hq[k], lat + i);
      end
   endtask

   task automatic do_reset(input logic pin);
      @(posedge mclk);
      #1;
      arst_n = 1'h0;
      lat_pin = pin;
      repeat (20) @(posedge mclk);
      `CHK({vld_k, vld_kn, echo, echo_n}, 4'h0);
      #1;
      arst_n = 1'h1;
      repeat (10) @(posedge kclk);
   endtask

   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic t_plain();
      clr();
      op(1'h1, 6'h00, 1'h0, 6'h05, W1, 8'h00);
      op(1'h1, 6'h00, 1'h1, 6'h00, '0, 8'hFF);
      op(1'h0, 6'h05, 1'h1, 6'h00, '0, 8'hFF);
      done(1);
      chk_burst(0, W1);
   endtask

   task automatic t_coherent();
      clr();
      op(1'h1, 6'h00, 1'h0, 6'h05, W2, MK);
      op(1'h0, 6'h05, 1'h1, 6'h00, '0, 8'hFF);
      done(1);
      chk_burst(0, merge(W1, W2, MK));
   endtask

   task automatic t_concurrent();
      clr();
      op(1'h0, 6'h05, 1'h0, 6'h09, W3, 8'h00);
      op(1'h0, 6'h09, 1'h1, 6'h00, '0, 8'hFF);
      done(2);
      chk_burst(0, merge(W1, W2, MK));
      chk_burst(1, W3);
   endtask

   task automatic t_desel();
      clr();
      op(1'h1, 6'h05, 1'h1, 6'h09, W1, 8'h00);
      op(1'h0, 6'h09, 1'h1, 6'h00, '0, 8'hFF);
      done(1);
      chk_burst(0, W3);
   endtask

   task automatic t_echo();
      logic e, en;
      // Start just after a complementary edge, clear of the launch time step
      @(posedge kclk_n);
      #1;
      repeat (4) begin
         e = echo;
         en = echo_n;
         @(posedge kclk);
         #1;
         `CHK({echo, echo_n}, {~e, en});
         @(posedge kclk_n);
         #1;
         `CHK({echo, echo_n}, {~e, ~en});
      end
   endtask

   task automatic run();
      t_plain();
      t_coherent();
      t_concurrent();
      t_desel();
      t_echo();
   endtask

   task automatic print_verdict();
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Short latency first, then a reset into long latency
   initial begin
      do_reset(1'h0);
      run();
      do_reset(1'h1);
      run();
      print_verdict();
   end
endmodule
